// >>> dv/sfh_front_bench.sv
`timescale 1ns/1ps
// self checking bench for the serial front
module sfh_front_bench;
   import sfh_pkg::*;
   logic clk, rstn, quad, busy, so, so_oe_n, paused, standby, busy_q, cs_n, sclk, si, pause_n;
   logic [7:0] sreg, creg, wr_data, op, q, d;
   logic [3:0] dummy;
   logic [23:0] addr;
   logic [31:0] r32;
   logic [31:0] seed = 32'h0000ef8d;
   wire [7:0] pul;
   wire so_wire;
   int num_errors = 0;
   int tests_run = 0;
   int cnt [8];
   int base [8];
   logic [7:0] ops [8];
   // serial output floats when not enabled
   assign so_wire = so_oe_n ? 1'bz : so;
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   sfh_host u_sfh_host (.i_core_clk(clk), .i_so(so_wire), .o_cs_n(cs_n), .o_sclk(sclk),
      .o_si(si), .o_pause_n(pause_n));
   sfh_front u_sfh_front (.i_core_clk(clk), .i_resetn(rstn), .i_cs_n(cs_n), .i_sclk(sclk),
      .i_si(si), .i_pause_n(pause_n), .i_quad_mode(quad), .i_busy(busy), .i_status_reg(sreg),
      .i_config_reg(creg), .o_so(so), .o_so_oe_n(so_oe_n), .o_paused(paused),
      .o_standby(standby), .o_busy(busy_q), .o_status_read(pul[0]), .o_config_read(pul[1]),
      .o_page_write(pul[2]), .o_half_block_erase(pul[3]), .o_sleep_entry(pul[4]),
      .o_quad_read(pul[5]), .o_dummy_cycles(dummy), .o_addr(addr), .o_wr_data(wr_data),
      .o_wr_data_vld(pul[6]), .o_reject(pul[7]));
   // free running strobe counters; each frame compares against a snapshot
   always @(posedge clk) begin
      for (int i = 0; i < 8; i++) cnt[i] <= rstn ? cnt[i] + int'(pul[i]) : 0;
   end
   // xorshift source, fixed seed
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic known(input logic [7:0] c);
      return c inside {OP_STATUS_READ, OP_CONFIG_READ, OP_PAGE_WRITE, OP_HALF_BLOCK_ERASE,
         OP_SLEEP_ENTRY, OP_QUAD_IO_READ};
   endfunction : known
   // expected strobe count k for one frame
   function automatic int exp_cnt(input logic [7:0] c, input int cut, input int nd, input int k);
      logic wr;
      wr = (c == OP_PAGE_WRITE) || (c == OP_HALF_BLOCK_ERASE) || (c == OP_SLEEP_ENTRY);
      if (k < 6) begin
         return int'(c == ops[k] && !(cut != 0 && k >= 2 && k <= 4));
      end
      if (k == 6) begin
         return (c == OP_PAGE_WRITE) ? nd : 0;
      end
      return int'(cut != 0 && wr);
   endfunction : exp_cnt
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic results();
      if (num_errors == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : results
   // one command frame, optionally cut off mid byte
   task automatic frame(input logic [7:0] c, input int cut, input int nd);
      logic [23:0] a;
      a = r32[31:8] ^ 24'h5a5a5a;
      base = cnt;
      u_sfh_host.sel();
      u_sfh_host.xfer(c, 8, q);
      if (c == OP_PAGE_WRITE || c == OP_HALF_BLOCK_ERASE) begin
         for (int i = 2; i >= 0; i--) u_sfh_host.xfer(a[8*i +: 8], 8, q);
      end
      for (int i = 0; i < nd && c == OP_PAGE_WRITE; i++) begin
         d = 8'(rnd() >> 3);
         u_sfh_host.xfer(d, 8, q);
      end
      if (c == OP_STATUS_READ || c == OP_CONFIG_READ) begin
         u_sfh_host.xfer(8'h00, 8, q);
         check(q, (c == OP_STATUS_READ) ? sreg : creg);
      end
      if (!known(c)) begin
         u_sfh_host.xfer(8'hff, 8, q);
         check({standby, so_oe_n}, 2'b11);
      end
      if (cut != 0) u_sfh_host.xfer(8'h00, 3, q);
      u_sfh_host.desel();
      for (int k = 0; k < 8; k++) check(cnt[k] - base[k], exp_cnt(c, cut, nd, k));
      if (c == OP_PAGE_WRITE || c == OP_HALF_BLOCK_ERASE) check(addr, a);
      if (c == OP_PAGE_WRITE) check(wr_data, d);
      if (c == OP_QUAD_IO_READ) check(dummy, creg[7] ? DUMMY_CNT_SEL1 : DUMMY_CNT_SEL0);
   endtask : frame
   initial begin
      rstn = 1'b0;
      quad = 1'b0;
      busy = 1'b0;
      sreg = 8'h00;
      creg = 8'h00;
      ops = '{OP_STATUS_READ, OP_CONFIG_READ, OP_PAGE_WRITE, OP_HALF_BLOCK_ERASE,
         OP_SLEEP_ENTRY, OP_QUAD_IO_READ, OP_QUAD_IO_READ, 8'h00};
      repeat (10) @(negedge clk);
      rstn = 1'b1;
      // every command, then again cut short off the byte boundary
      for (int t = 0; t < 24; t++) begin
         r32 = rnd();
         sreg = r32[7:0];
         creg = {t[0], r32[14:8]};
         busy = r32[15];
         op = known(ops[t % 8]) ? ops[t % 8] : r32[23:16];
         if (t % 8 == 7 && known(op)) op = 8'h3c;
         frame(op, t / 16, 1 + t % 3);
      end
      // pause in mid read, with sclk and si noise while paused
      base = cnt;
      u_sfh_host.sel();
      u_sfh_host.xfer(OP_STATUS_READ, 8, q);
      u_sfh_host.xfer(8'h00, 4, q);
      u_sfh_host.pins(1'b0, 1'b0);
      check({paused, so_oe_n}, 2'b11);
      u_sfh_host.pins(1'b1, 1'b0);
      u_sfh_host.pins(1'b0, 1'b0);
      u_sfh_host.pins(1'b0, 1'b1);
      check(paused, 1'b0);
      u_sfh_host.xfer(8'h00, 4, d);
      check({q[7:4], d[7:4]}, sreg);
      u_sfh_host.desel();
      check(cnt[0] - base[0], 1);
      // pause edges with sclk high, then deselect while paused
      busy = 1'b1;
      base = cnt;
      u_sfh_host.sel();
      u_sfh_host.xfer(OP_HALF_BLOCK_ERASE, 8, q);
      u_sfh_host.pins(1'b1, 1'b1);
      u_sfh_host.pins(1'b1, 1'b0);
      check(paused, 1'b0);
      u_sfh_host.pins(1'b0, 1'b0);
      check(paused, 1'b1);
      u_sfh_host.pins(1'b1, 1'b0);
      u_sfh_host.pins(1'b1, 1'b1);
      check({paused, busy_q}, 2'b11);
      u_sfh_host.pins(1'b0, 1'b0);
      u_sfh_host.desel();
      check(paused, 1'b0);
      check(cnt[3] - base[3] + cnt[7] - base[7], 0);
      busy = 1'b0;
      frame(OP_SLEEP_ENTRY, 0, 1);
      // quad mode leaves the pause pin without effect
      quad = 1'b1;
      u_sfh_host.sel();
      u_sfh_host.xfer(OP_QUAD_IO_READ, 8, q);
      u_sfh_host.pins(1'b0, 1'b0);
      check(paused, 1'b0);
      u_sfh_host.desel();
      quad = 1'b0;
      results();
   end
   // hang guard, well past the expected run length
   initial begin
      repeat (60000) @(posedge clk);
      num_errors++;
      results();
   end
endmodule : sfh_front_bench
bind sfh_front sfh_front_properties u_sfh_front_properties (.i_core_clk(i_core_clk),
   .i_resetn(i_resetn), .i_cs_n(i_cs_n), .i_sclk(i_sclk), .i_pause_n(i_pause_n),
   .i_quad_mode(i_quad_mode), .i_busy(i_busy), .o_so(o_so), .o_so_oe_n(o_so_oe_n),
   .o_paused(o_paused), .o_standby(o_standby), .o_busy(o_busy), .o_page_write(o_page_write),
   .o_half_block_erase(o_half_block_erase), .o_sleep_entry(o_sleep_entry), .o_reject(o_reject));

// >>> dv/sfh_front_properties.sv
`timescale 1ns/1ps
// pin level timing checks for the serial front
module sfh_front_properties (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_cs_n,
   input wire logic i_sclk,
   input wire logic i_pause_n,
   input wire logic i_quad_mode,
   input wire logic i_busy,
   input wire logic o_so,
   input wire logic o_so_oe_n,
   input wire logic o_paused,
   input wire logic o_standby,
   input wire logic o_busy,
   input wire logic o_page_write,
   input wire logic o_half_block_erase,
   input wire logic o_sleep_entry,
   input wire logic o_reject
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_resetn);
   // any commit strobe
   logic commit;
   assign commit = o_page_write | o_half_block_erase | o_sleep_entry;
   // pause asked inside a frame while sclk is low
   sequence pause_asked;
      !i_pause_n && !i_sclk && !i_cs_n && !i_quad_mode;
   endsequence
   // pause pin released while sclk is low
   sequence pause_freed;
      i_pause_n && !i_sclk;
   endsequence
   // sclk low somewhere in the synchroniser window
   sequence sclk_was_low;
      !$past(i_sclk, 2) || !$past(i_sclk, 3) || !$past(i_sclk, 4);
   endsequence
   a_pause_enter: assert property (pause_asked [*5] |-> o_paused)
      else $error("pause not entered");
   a_pause_exit: assert property (pause_freed [*5] |-> !o_paused)
      else $error("pause not left");
   a_enter_sclk_low: assert property ($rose(o_paused) |-> sclk_was_low)
      else $error("pause entered while sclk high");
   a_exit_sclk_low: assert property (
      $fell(o_paused) && !i_cs_n && !i_quad_mode |-> sclk_was_low)
      else $error("pause left while sclk high");
   a_pause_float: assert property (o_paused [*2] |-> o_so_oe_n)
      else $error("output driven while paused");
   a_standby_float: assert property (o_standby |-> o_so_oe_n)
      else $error("output driven in standby");
   a_quad_nopause: assert property (i_quad_mode [*4] |-> !o_paused)
      else $error("paused in quad mode");
   // deselect clears pause and floats output
   a_deselect_clear: assert property (i_cs_n [*5] |-> !o_paused && o_so_oe_n)
      else $error("deselect left pause or output on");
   // busy flows on through a pause
   a_busy_paused: assert property (o_paused |-> o_busy == $past(i_busy))
      else $error("busy stalled by pause");
   a_commit_after_cs: assert property (commit |-> $past(i_cs_n, 2))
      else $error("commit inside a frame");
   a_reject_nocommit: assert property (o_reject |-> !commit [*5])
      else $error("commit after reject");
   // output moves only after sclk falls
   a_so_on_fall: assert property ($changed(o_so) && !i_cs_n |-> sclk_was_low)
      else $error("output changed with sclk high");
endmodule : sfh_front_properties

// >>> dv/sfh_host.sv
`timescale 1ns/1ps
// host controller model in mode 0, pins move on falling core edges
module sfh_host (
   input wire logic i_core_clk,
   input wire logic i_so,
   output logic o_cs_n,
   output logic o_sclk,
   output logic o_si,
   output logic o_pause_n
);
   // idle pins at time zero
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_si = 1'b0;
      o_pause_n = 1'b1;
   end
   // wait n falling core edges
   task automatic tick(input int n);
      repeat (n) @(negedge i_core_clk);
   endtask : tick
   task automatic sel();
      o_pause_n = 1'b1;
      tick(4);
      o_cs_n = 1'b0;
      tick(4);
   endtask : sel
   // msb first, read back at each sclk rise
   task automatic xfer(input logic [7:0] d, input int n, output logic [7:0] q);
      q = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         o_si = d[i];
         tick(4);
         o_sclk = 1'b1;
         q[i] = i_so;
         tick(4);
         o_sclk = 1'b0;
      end
   endtask : xfer
   // release select; si is stale afterwards so it flips
   task automatic desel();
      tick(4);
      o_cs_n = 1'b1;
      o_si = ~o_si;
      tick(12);
   endtask : desel
   // pause and sclk moved while selected; si wiggles as noise
   task automatic pins(input logic clk, input logic pz);
      o_sclk = clk;
      o_pause_n = pz;
      o_si = ~o_si;
      tick(6);
   endtask : pins
endmodule : sfh_host

// >>> logic/sfh_front.sv
`timescale 1ns/1ps
module sfh_front
   import sfh_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_cs_n,
   input wire logic i_sclk,
   input wire logic i_si,
   input wire logic i_pause_n,
   input wire logic i_quad_mode,
   input wire logic i_busy,
   input wire logic [7:0] i_status_reg,
   input wire logic [7:0] i_config_reg,
   output logic o_so,
   output logic o_so_oe_n,
   output logic o_paused,
   output logic o_standby,
   output logic o_busy,
   output logic o_status_read,
   output logic o_config_read,
   output logic o_page_write,
   output logic o_half_block_erase,
   output logic o_sleep_entry,
   output logic o_quad_read,
   output logic [3:0] o_dummy_cycles,
   output logic [23:0] o_addr,
   output logic [7:0] o_wr_data,
   output logic o_wr_data_vld,
   output logic o_reject
);
   // synchronised pins
   logic [SYNC_W-1:0] pins_sync;
   logic cs_n_s;
   logic sclk_s;
   logic si_s;
   logic pause_n_s;
   // pause tracker outputs
   logic paused;
   logic iface_reset;
   // previous levels for edge finding
   logic cs_n_prev_ff;
   logic sclk_prev_ff;
   // edges of the synchronised pins
   logic cs_fall;
   logic cs_rise;
   logic sclk_rise;
   logic sclk_fall;
   // command state
   sfh_state_e state_ff;
   sfh_cmd_e cmd_ff;
   logic [2:0] bit_cnt_ff;
   logic [1:0] byte_cnt_ff;
   logic [7:0] in_sr_ff;
   logic [7:0] out_sr_ff;
   logic out_started_ff;
   // received byte including the bit on this edge
   logic [7:0] in_byte;
   logic byte_done;
   sfh_cmd_e dec_cmd;
   // registered outputs
   logic so_ff;
   logic so_oe_n_ff;
   logic standby_ff;
   logic busy_ff;
   logic status_read_ff;
   logic config_read_ff;
   logic page_write_ff;
   logic half_block_erase_ff;
   logic sleep_entry_ff;
   logic quad_read_ff;
   logic [3:0] dummy_ff;
   logic [23:0] addr_ff;
   logic [7:0] wr_data_ff;
   logic wr_data_vld_ff;
   logic reject_ff;

   // all pins cross into the core clock first
   sfh_sync u_sync (
      .i_core_clk(i_core_clk),
      .i_resetn(i_resetn),
      .i_async({i_cs_n, i_sclk, i_si, i_pause_n}),
      // idle pin levels: select high, sclk low (mode 0), si high, pause high,
      // so the edge finders see no false sclk edge after reset
      .i_rst_val({1'b1, 1'b0, 1'b1, 1'b1}),
      .o_sync(pins_sync)
   );
   assign cs_n_s = pins_sync[3];
   assign sclk_s = pins_sync[2];
   assign si_s = pins_sync[1];
   assign pause_n_s = pins_sync[0];

   // pause tracking; quad mode keeps it off
   // quad disables pause
   sfh_pause u_pause (
      .i_core_clk(i_core_clk),
      .i_resetn(i_resetn),
      .i_cs_n(cs_n_s),
      .i_sclk(sclk_s),
      .i_pause_n(pause_n_s),
      .i_quad_mode(i_quad_mode),
      .o_paused(paused),
      .o_iface_reset(iface_reset)
   );

   // edge history, always running so a resume sees no stale edge
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         cs_n_prev_ff <= 1'b1;
         sclk_prev_ff <= 1'b0;
      end else begin
         cs_n_prev_ff <= cs_n_s;
         sclk_prev_ff <= sclk_s;
      end
   end

   assign cs_fall = cs_n_prev_ff && !cs_n_s;
   assign cs_rise = !cs_n_prev_ff && cs_n_s;
   assign sclk_rise = !sclk_prev_ff && sclk_s && !paused && !cs_n_s;
   assign sclk_fall = sclk_prev_ff && !sclk_s && !paused && !cs_n_s;
   assign in_byte = {in_sr_ff[6:0], si_s};
   assign byte_done = sclk_rise && (bit_cnt_ff == BIT_LAST_IDX);
   assign dec_cmd = sfh_decode(in_byte);

   // input shifter and counters, frozen while paused
   // freeze on pause
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn || cs_fall) begin
         in_sr_ff <= BYTE_RST;
         bit_cnt_ff <= 3'h0;
         byte_cnt_ff <= 2'h0;
      end else if (sclk_rise) begin
         in_sr_ff <= in_byte;
         bit_cnt_ff <= bit_cnt_ff + 3'h1;
         if (byte_done && state_ff != ST_OPCODE) begin
            byte_cnt_ff <= byte_cnt_ff + 2'h1;
         end
      end
   end

   // command sequencer
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn || iface_reset) begin
         state_ff <= ST_IDLE;
         cmd_ff <= CMD_NONE;
      end else if (cs_fall) begin
         state_ff <= ST_OPCODE;
         cmd_ff <= CMD_NONE;
      end else if (cs_n_s) begin
         state_ff <= ST_IDLE;
      end else if (byte_done) begin
         case (state_ff)
            ST_OPCODE: begin
               cmd_ff <= dec_cmd;
               if (dec_cmd == CMD_NONE) begin
                  state_ff <= ST_STANDBY;
               end else if (sfh_has_addr(dec_cmd)) begin
                  state_ff <= ST_ADDR;
               end else if (dec_cmd == CMD_STATUS_READ || dec_cmd == CMD_CONFIG_READ) begin
                  state_ff <= ST_DATA_OUT;
               end else begin
                  state_ff <= ST_DONE;
               end
            end
            ST_ADDR: begin
               if (byte_cnt_ff == ADDR_LAST_IDX) begin
                  state_ff <= (cmd_ff == CMD_PAGE_WRITE) ? ST_DATA_IN : ST_DONE;
               end
            end
            default: begin
               // data and done states hold until deselect
               state_ff <= state_ff;
            end
         endcase
      end
   end

   // address capture, three bytes msb first
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         addr_ff <= ADDR_RST;
      end else if (byte_done && state_ff == ST_ADDR) begin
         addr_ff <= {addr_ff[15:0], in_byte};
      end
   end

   // program data bytes, one pulse each
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         wr_data_ff <= BYTE_RST;
         wr_data_vld_ff <= 1'b0;
      end else begin
         wr_data_vld_ff <= byte_done && state_ff == ST_DATA_IN;
         if (byte_done && state_ff == ST_DATA_IN) begin
            wr_data_ff <= in_byte;
         end
      end
   end

   // read commands announce themselves at decode
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         status_read_ff <= 1'b0;
         config_read_ff <= 1'b0;
         quad_read_ff <= 1'b0;
         dummy_ff <= DUMMY_RST;
      end else begin
         status_read_ff <= byte_done && state_ff == ST_OPCODE && dec_cmd == CMD_STATUS_READ;
         config_read_ff <= byte_done && state_ff == ST_OPCODE && dec_cmd == CMD_CONFIG_READ;
         quad_read_ff <= byte_done && state_ff == ST_OPCODE && dec_cmd == CMD_QUAD_IO_READ;
         if (byte_done && state_ff == ST_OPCODE && dec_cmd == CMD_QUAD_IO_READ) begin
            dummy_ff <= i_config_reg[CFG_DUMMY_SEL_BIT] ? DUMMY_CNT_SEL1 : DUMMY_CNT_SEL0;
         end
      end
   end

   // write type commands commit only at deselect, on a byte boundary;
   // a pause-time deselect goes through iface_reset and commits nothing
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         page_write_ff <= 1'b0;
         half_block_erase_ff <= 1'b0;
         sleep_entry_ff <= 1'b0;
         reject_ff <= 1'b0;
      end else begin
         page_write_ff <= 1'b0;
         half_block_erase_ff <= 1'b0;
         sleep_entry_ff <= 1'b0;
         reject_ff <= 1'b0;
         if (cs_rise && !paused) begin
            case (state_ff)
               ST_DATA_IN: begin
                  page_write_ff <= (bit_cnt_ff == 3'h0);
                  reject_ff <= (bit_cnt_ff != 3'h0);
               end
               ST_DONE: begin
                  half_block_erase_ff <= (cmd_ff == CMD_HALF_BLOCK_ERASE) && (bit_cnt_ff == 3'h0);
                  sleep_entry_ff <= (cmd_ff == CMD_SLEEP_ENTRY) && (bit_cnt_ff == 3'h0);
                  reject_ff <= (cmd_ff != CMD_QUAD_IO_READ) && (bit_cnt_ff != 3'h0);
               end
               ST_ADDR: begin
                  // cut short inside the address
                  reject_ff <= 1'b1;
               end
               default: begin
                  reject_ff <= 1'b0;
               end
            endcase
         end
      end
   end

   // output shifter; register reloads every byte so it repeats
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn || cs_fall) begin
         out_sr_ff <= BYTE_RST;
         out_started_ff <= 1'b0;
         so_ff <= 1'b0;
      end else if (byte_done && state_ff == ST_OPCODE) begin
         out_sr_ff <= (dec_cmd == CMD_CONFIG_READ) ? i_config_reg : i_status_reg;
      end else if (sclk_fall && state_ff == ST_DATA_OUT) begin
         so_ff <= out_sr_ff[7];
         out_started_ff <= 1'b1;
         if (bit_cnt_ff == 3'h0) begin
            // fresh status or config value at each byte
            // bit 7 goes out now, so the shifter keeps only bits 6..0
            out_sr_ff <= (cmd_ff == CMD_CONFIG_READ) ? {i_config_reg[6:0], 1'b0}
                                                     : {i_status_reg[6:0], 1'b0};
            so_ff <= (cmd_ff == CMD_CONFIG_READ) ? i_config_reg[7] : i_status_reg[7];
         end else begin
            out_sr_ff <= {out_sr_ff[6:0], 1'b0};
         end
      end
   end

   // first fall of each byte loads bit 7 directly, later falls take from the shifter
   // output enable, active low while driving
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         so_oe_n_ff <= 1'b1;
      end else begin
         so_oe_n_ff <= !(state_ff == ST_DATA_OUT && out_started_ff && !paused && !cs_n_s);
      end
   end

   // status indications
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         standby_ff <= 1'b0;
         busy_ff <= 1'b0;
      end else begin
         standby_ff <= (state_ff == ST_STANDBY);
         busy_ff <= i_busy;
      end
   end

   assign o_so = so_ff;
   assign o_so_oe_n = so_oe_n_ff;
   assign o_paused = paused;
   assign o_standby = standby_ff;
   assign o_busy = busy_ff;
   assign o_status_read = status_read_ff;
   assign o_config_read = config_read_ff;
   assign o_page_write = page_write_ff;
   assign o_half_block_erase = half_block_erase_ff;
   assign o_sleep_entry = sleep_entry_ff;
   assign o_quad_read = quad_read_ff;
   assign o_dummy_cycles = dummy_ff;
   assign o_addr = addr_ff;
   assign o_wr_data = wr_data_ff;
   assign o_wr_data_vld = wr_data_vld_ff;
   assign o_reject = reject_ff;
endmodule : sfh_front

// >>> logic/sfh_pause.sv
`timescale 1ns/1ps
// pause (hold) tracker on synchronised pin levels
module sfh_pause
   import sfh_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_cs_n,
   input wire logic i_sclk,
   input wire logic i_pause_n,
   input wire logic i_quad_mode,
   output logic o_paused,
   output logic o_iface_reset
);
   // pause state
   logic paused_ff;
   // one cycle reset request
   logic iface_reset_ff;

   // level based: a pending edge simply waits for sclk low
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         paused_ff <= 1'b0;
      end else if (i_cs_n || i_quad_mode) begin
         // deselect or quad mode clears it
         paused_ff <= 1'b0;
      end else if (!paused_ff && !i_pause_n && !i_sclk) begin
         paused_ff <= 1'b1;
      end else if (paused_ff && i_pause_n && !i_sclk) begin
         paused_ff <= 1'b0;
      end
   end

   // deselect during pause throws away the command
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         iface_reset_ff <= 1'b0;
      end else begin
         iface_reset_ff <= paused_ff && i_cs_n;
      end
   end

   assign o_paused = paused_ff;
   assign o_iface_reset = iface_reset_ff;
endmodule : sfh_pause

// >>> logic/sfh_pkg.sv
package sfh_pkg;

   // first byte codes that this front end understands
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_CONFIG_READ = 8'h15;
   localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
   localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;
   localparam logic [7:0] OP_SLEEP_ENTRY = 8'hb9;
   localparam logic [7:0] OP_QUAD_IO_READ = 8'heb;

   // position of the dummy_cycle_select bit in the configuration register
   localparam int CFG_DUMMY_SEL_BIT = 7;
   // dummy cycle counts for the two settings of dummy_cycle_select
   localparam logic [3:0] DUMMY_CNT_SEL0 = 4'h6;
   localparam logic [3:0] DUMMY_CNT_SEL1 = 4'h8;

   // index of the last address byte (three bytes, 0..2)
   localparam logic [1:0] ADDR_LAST_IDX = 2'h2;
   // index of the last bit in a byte
   localparam logic [2:0] BIT_LAST_IDX = 3'h7;

   // reset values of the captured fields
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [23:0] ADDR_RST = 24'h000000;
   localparam logic [3:0] DUMMY_RST = 4'h0;

   // width of the synchroniser bank: cs_n, sclk, si, pause_n
   localparam int SYNC_W = 4;

   // command kinds after the opcode is decoded
   typedef enum logic [2:0] {
      CMD_NONE,
      CMD_STATUS_READ,
      CMD_CONFIG_READ,
      CMD_PAGE_WRITE,
      CMD_HALF_BLOCK_ERASE,
      CMD_SLEEP_ENTRY,
      CMD_QUAD_IO_READ
   } sfh_cmd_e;

   // serial front states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_OPCODE,
      ST_ADDR,
      ST_DATA_IN,
      ST_DATA_OUT,
      ST_DONE,
      ST_STANDBY
   } sfh_state_e;

   // opcode byte to command kind
   function automatic sfh_cmd_e sfh_decode(input logic [7:0] op);
      sfh_cmd_e k;
      k = CMD_NONE;
      if (op == OP_STATUS_READ) begin
         k = CMD_STATUS_READ;
      end else if (op == OP_CONFIG_READ) begin
         k = CMD_CONFIG_READ;
      end else if (op == OP_PAGE_WRITE) begin
         k = CMD_PAGE_WRITE;
      end else if (op == OP_HALF_BLOCK_ERASE) begin
         k = CMD_HALF_BLOCK_ERASE;
      end else if (op == OP_SLEEP_ENTRY) begin
         k = CMD_SLEEP_ENTRY;
      end else if (op == OP_QUAD_IO_READ) begin
         k = CMD_QUAD_IO_READ;
      end
      return k;
   endfunction : sfh_decode

   // commands that carry three address bytes
   function automatic logic sfh_has_addr(input sfh_cmd_e k);
      return (k == CMD_PAGE_WRITE) || (k == CMD_HALF_BLOCK_ERASE);
   endfunction : sfh_has_addr

endpackage : sfh_pkg

// >>> logic/sfh_sync.sv
`timescale 1ns/1ps
// two flop synchroniser bank for pin inputs
module sfh_sync
   import sfh_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic [SYNC_W-1:0] i_async,
   input wire logic [SYNC_W-1:0] i_rst_val,
   output logic [SYNC_W-1:0] o_sync
);
   // first stage, read only by the second stage
   logic [SYNC_W-1:0] meta_ff;
   // second stage, safe to use
   logic [SYNC_W-1:0] sync_ff;

   genvar g;
   generate
      for (g = 0; g < SYNC_W; g++) begin : g_bit
         // reset to idle level, not to the pin value
         always_ff @(posedge i_core_clk) begin
            if (!i_resetn) begin
               meta_ff[g] <= i_rst_val[g];
               sync_ff[g] <= i_rst_val[g];
            end else begin
               meta_ff[g] <= i_async[g];
               sync_ff[g] <= meta_ff[g];
            end
         end
      end
   endgenerate

   // only the second stage leaves the bank
   assign o_sync = sync_ff;
endmodule : sfh_sync
